// File: logic/mrc_pkg.sv
package mrc_pkg;

   // ----------------------------------------------------------------
   // clock periods
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   // input reference clock and pll reference clock both run at the core clock rate
   localparam int INPUT_REF_PERIOD_NS = 10;
   localparam int PLL_REF_PERIOD_NS = 10;

   // ----------------------------------------------------------------
   // sequence delays, figures in cycles of their own clock
   // ----------------------------------------------------------------
   localparam int POR_REL_INPUT_CYC = 1024;
   localparam int HARD_REL_REF_CYC = 512;
   localparam int SOFT_REL_REF_CYC = 515;
   localparam int SOFT_HOLD_REF_CYC = 515;
   localparam int GUARD_CYC_INT = 3;

   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] POR_REL_CYC =
      CNT_W'((POR_REL_INPUT_CYC * INPUT_REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] HARD_REL_CYC =
      CNT_W'((HARD_REL_REF_CYC * PLL_REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SOFT_REL_CYC =
      CNT_W'((SOFT_REL_REF_CYC * PLL_REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SOFT_HOLD_CYC =
      CNT_W'((SOFT_HOLD_REF_CYC * PLL_REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] GUARD_CYC = CNT_W'(GUARD_CYC_INT);
   localparam logic [CNT_W-1:0] CNT_MAX = 11'h7ff;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int HARD_CFG_W = 32;
   localparam int PIN_SYNC_W = 4;
   localparam int STRAP_W = 11;
   // por asserted, hard and soft pins high, pll not locked
   localparam logic [PIN_SYNC_W-1:0] PIN_SYNC_INIT = 4'h6;
   localparam logic [STRAP_W-1:0] STRAP_INIT = 11'h000;
   localparam logic [HARD_CFG_W-1:0] HARD_CFG_INIT = 32'h0000_0000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] clock_mode_select;
      logic rst_cfg_mode;
      logic [2:0] boot_mode;
      logic [3:0] chip_id;
      logic wide_port_dsi;
   } mrc_strap_s;

   typedef struct packed {
      logic power_on;
      logic ext_hard;
      logic ext_soft;
      logic watchdog;
      logic bus_monitor;
      logic tap_soft;
   } mrc_status_s;

   localparam mrc_status_s STATUS_INIT = 6'h20;

   typedef enum logic [2:0] {
      ST_POR_HOLD,
      ST_POR_WAIT,
      ST_PLL_WAIT,
      ST_HARD,
      ST_SOFT,
      ST_GUARD,
      ST_IDLE
   } mrc_state_e;

endpackage

// File: logic/mrc_sync.sv
`timescale 1ns/100ps
module mrc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // ----------------------------------------------------------------
   // two-stage synchroniser, first stage read only by the second
   // ----------------------------------------------------------------
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= INIT;
         q <= INIT;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// File: logic/mrc_top.sv
`timescale 1ns/100ps
module mrc_top
   import mrc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic power_on_reset_n,
   input wire logic hard_reset_pin_n_i,
   output logic hard_reset_pin_n_o,
   output logic hard_reset_pin_n_oe,
   input wire logic soft_reset_pin_n_i,
   output logic soft_reset_pin_n_o,
   output logic soft_reset_pin_n_oe,
   input wire logic watchdog_zero,
   input wire logic watchdog_en,
   input wire logic bus_mon_zero,
   input wire logic bus_mon_en,
   input wire logic tap_soft_req,
   input wire logic system_pll_lock,
   output logic system_pll_reset,
   output logic por_internal_n,
   output logic core_reset_n,
   input wire mrc_strap_s strap_pins,
   output mrc_strap_s strap_cfg,
   input wire logic [HARD_CFG_W-1:0] hard_cfg_word,
   output logic [HARD_CFG_W-1:0] hard_cfg,
   output logic cfg_sample,
   output mrc_status_s reset_status
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [PIN_SYNC_W-1:0] pin_raw;
   logic [PIN_SYNC_W-1:0] pin_sync;
   logic [STRAP_W-1:0] strap_sync;
   logic por_s;
   logic hard_s;
   logic soft_s;
   logic lock_s;

   assign pin_raw = {power_on_reset_n, hard_reset_pin_n_i, soft_reset_pin_n_i,
                     system_pll_lock};

   mrc_sync #(
      .W(PIN_SYNC_W),
      .INIT(PIN_SYNC_INIT)
   ) u_pin_sync (
      .clk(clk),
      .resetn(resetn),
      .d(pin_raw),
      .q(pin_sync)
   );

   // straps are pins too, so they get the same treatment
   mrc_sync #(
      .W(STRAP_W),
      .INIT(STRAP_INIT)
   ) u_strap_sync (
      .clk(clk),
      .resetn(resetn),
      .d(strap_pins),
      .q(strap_sync)
   );

   assign por_s = pin_sync[3];
   assign hard_s = pin_sync[2];
   assign soft_s = pin_sync[1];
   assign lock_s = pin_sync[0];

   // ----------------------------------------------------------------
   // state and counter
   // ----------------------------------------------------------------
   mrc_state_e state_r;
   mrc_state_e state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic hard_oe_r;
   logic hard_oe_nxt;
   logic soft_oe_r;
   logic soft_oe_nxt;
   logic core_rst_r;
   logic core_rst_nxt;
   logic pll_rst_r;
   logic pll_rst_nxt;
   logic por_int_r;
   logic por_int_nxt;
   logic sample_r;
   logic sample_nxt;
   mrc_strap_s strap_r;
   logic [HARD_CFG_W-1:0] hard_cfg_r;
   mrc_status_s status_r;
   mrc_status_s status_nxt;

   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   wire por_req = !por_s;
   wire wdt_req = watchdog_zero && watchdog_en;
   wire bm_req = bus_mon_zero && bus_mon_en;
   // we never drive the pins in idle, so a low level here is external
   wire ext_hard_req = !hard_s;
   wire ext_soft_req = !soft_s;
   wire hard_req = ext_hard_req || wdt_req || bm_req;
   wire soft_req = ext_soft_req || tap_soft_req;
   wire in_idle = (state_r == ST_IDLE);
   wire in_soft = (state_r == ST_SOFT);
   wire in_hard = (state_r == ST_HARD);
   wire in_por = (state_r == ST_POR_HOLD) || (state_r == ST_POR_WAIT);
   wire in_pll = (state_r == ST_PLL_WAIT);
   wire por_done = (cnt_r >= POR_REL_CYC - 11'h001);
   wire hard_rel = (cnt_r >= HARD_REL_CYC);
   wire soft_rel = (cnt_r >= SOFT_REL_CYC);
   wire soft_hold_done = (cnt_r >= SOFT_HOLD_CYC);
   wire guard_done = (cnt_r >= GUARD_CYC);
   wire pins_high = hard_s && soft_s;
   wire hard_done = soft_rel && hard_s;
   wire start_hard = (state_nxt == ST_HARD) && (in_idle || in_soft);
   wire start_soft = (state_nxt == ST_SOFT) && in_idle;
   wire start_por = (state_nxt == ST_POR_HOLD) && !(state_r == ST_POR_HOLD);
   wire por_released = (state_r == ST_POR_HOLD) && (state_nxt == ST_POR_WAIT);
   wire hard_entry = (state_nxt == ST_HARD) && !in_hard;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      if (por_req) begin
         state_nxt = ST_POR_HOLD;
      end else begin
         case (state_r)
            ST_POR_HOLD: begin
               state_nxt = ST_POR_WAIT;
            end
            ST_POR_WAIT: begin
               if (por_done) begin
                  state_nxt = ST_PLL_WAIT;
               end
            end
            ST_PLL_WAIT: begin
               if (lock_s) begin
                  state_nxt = ST_HARD;
               end
            end
            ST_HARD: begin
               if (hard_done) begin
                  state_nxt = ST_GUARD;
               end
            end
            ST_SOFT: begin
               // hard requests pre-empt a running soft sequence
               if (hard_req) begin
                  state_nxt = ST_HARD;
               end else if (soft_hold_done) begin
                  state_nxt = ST_GUARD;
               end
            end
            ST_GUARD: begin
               // waits out the synchroniser lag so our own release is not seen
               if (guard_done && pins_high) begin
                  state_nxt = ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (hard_req) begin
                  state_nxt = ST_HARD;
               end else if (soft_req) begin
                  state_nxt = ST_SOFT;
               end
            end
            default: begin
               state_nxt = ST_POR_HOLD;
            end
         endcase
      end
   end

   assign cnt_nxt = (state_nxt != state_r) ? '0 :
                    (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 11'h001;

   // ----------------------------------------------------------------
   // pin and reset outputs
   // ----------------------------------------------------------------
   assign pll_rst_nxt = (state_nxt == ST_POR_HOLD) || (state_nxt == ST_POR_WAIT);
   assign por_int_nxt = pll_rst_nxt;
   assign hard_oe_nxt = in_por || in_pll || (in_hard && !hard_rel) || por_req;
   // soft stays low as long as the hard pin is low, driven by anyone, except for one cycle when a hard request pre-empts soft
   assign soft_oe_nxt = hard_oe_nxt ||
                        (in_hard && !(soft_rel && hard_s)) ||
                        (in_soft && !soft_hold_done && !hard_req);
   assign core_rst_nxt = !(state_nxt == ST_GUARD || state_nxt == ST_IDLE);
   assign sample_nxt = por_released || hard_entry;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_POR_HOLD;
         cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hard_oe_r <= 1'b1;
         soft_oe_r <= 1'b1;
         core_rst_r <= 1'b1;
         pll_rst_r <= 1'b1;
         por_int_r <= 1'b1;
         sample_r <= 1'b0;
      end else begin
         hard_oe_r <= hard_oe_nxt;
         soft_oe_r <= soft_oe_nxt;
         core_rst_r <= core_rst_nxt;
         pll_rst_r <= pll_rst_nxt;
         por_int_r <= por_int_nxt;
         sample_r <= sample_nxt;
      end
   end

   // ----------------------------------------------------------------
   // configuration capture
   // ----------------------------------------------------------------
   // straps track the pins only while power-on reset holds, freezing at release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         strap_r <= STRAP_INIT;
      end else if (state_r == ST_POR_HOLD) begin
         strap_r <= strap_sync;
      end
   end

   // word must be stable at the hard sequence entry
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hard_cfg_r <= HARD_CFG_INIT;
      end else if (hard_entry) begin
         hard_cfg_r <= hard_cfg_word;
      end
   end

   // ----------------------------------------------------------------
   // reset cause record
   // ----------------------------------------------------------------
   always_comb begin
      status_nxt = status_r;
      if (start_por) begin
         status_nxt = STATUS_INIT;
      end else if (start_hard) begin
         status_nxt = '0;
         status_nxt.ext_hard = ext_hard_req;
         status_nxt.watchdog = wdt_req;
         status_nxt.bus_monitor = bm_req;
      end else if (start_soft) begin
         status_nxt = '0;
         status_nxt.ext_soft = ext_soft_req;
         status_nxt.tap_soft = tap_soft_req;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_r <= STATUS_INIT;
      end else begin
         status_r <= status_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // open-drain: the output value is low, only the enable moves
   assign hard_reset_pin_n_o = 1'b0;
   assign hard_reset_pin_n_oe = hard_oe_r;
   assign soft_reset_pin_n_o = 1'b0;
   assign soft_reset_pin_n_oe = soft_oe_r;
   assign system_pll_reset = pll_rst_r;
   assign por_internal_n = !por_int_r;
   assign core_reset_n = !core_rst_r;
   assign strap_cfg = strap_r;
   assign hard_cfg = hard_cfg_r;
   assign cfg_sample = sample_r;
   assign reset_status = status_r;

endmodule

// File: verif/mrc_top_monitor.sv
`timescale 1ns/100ps
module mrc_top_monitor
   import mrc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic power_on_reset_n,
   input wire logic hard_reset_pin_n_i,
   input wire logic hard_reset_pin_n_o,
   input wire logic hard_reset_pin_n_oe,
   input wire logic soft_reset_pin_n_i,
   input wire logic soft_reset_pin_n_o,
   input wire logic soft_reset_pin_n_oe,
   input wire logic watchdog_zero,
   input wire logic watchdog_en,
   input wire logic bus_mon_zero,
   input wire logic bus_mon_en,
   input wire logic tap_soft_req,
   input wire logic system_pll_lock,
   input wire logic system_pll_reset,
   input wire logic por_internal_n,
   input wire logic core_reset_n,
   input wire mrc_strap_s strap_cfg,
   input wire logic [HARD_CFG_W-1:0] hard_cfg,
   input wire logic cfg_sample
);
   // ------------------------------------------------
   // hard and soft counters restart on lock so por path is timed from lock; p_cnt_r restarts only on power_on_reset_n low
   // ------------------------------------------------
   logic [11:0] h_cnt_r, s_cnt_r, p_cnt_r;
   logic lock_d_r;
   logic quiet;
   assign quiet = core_reset_n && por_internal_n && hard_reset_pin_n_i && soft_reset_pin_n_i;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         h_cnt_r <= '0;
         s_cnt_r <= '0;
         p_cnt_r <= '0;
         lock_d_r <= 1'b0;
      end else begin
         lock_d_r <= system_pll_lock;
         h_cnt_r <= (!hard_reset_pin_n_oe || (system_pll_lock && !lock_d_r)) ? '0 :
            h_cnt_r + 12'(h_cnt_r != 12'hfff);
         s_cnt_r <= (!soft_reset_pin_n_oe || (system_pll_lock && !lock_d_r)) ? '0 :
            s_cnt_r + 12'(s_cnt_r != 12'hfff);
         p_cnt_r <= !power_on_reset_n ? '0 : p_cnt_r + 12'(p_cnt_r != 12'hfff);
      end
   end
   // ------------------------------------------------
   // properties
   // ------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_hard_forces_soft:
      assert property (hard_reset_pin_n_oe |-> soft_reset_pin_n_oe) else $error("soft not driven");
   a_hard_pin_od:
      assert property (hard_reset_pin_n_o == 1'b0) else $error("hard pin driven high");
   a_soft_pin_od:
      assert property (soft_reset_pin_n_o == 1'b0) else $error("soft pin driven high");
   a_por_drives_all:
      assert property (!por_internal_n |-> hard_reset_pin_n_oe && soft_reset_pin_n_oe
         && system_pll_reset && !core_reset_n) else $error("por actions missing");
   a_por_takes_over:
      assert property ($fell(power_on_reset_n) |-> ##[1:4] !por_internal_n)
      else $error("por not taken");
   a_por_release_time:
      assert property ($rose(por_internal_n) |-> p_cnt_r >= 1024 && p_cnt_r <= 1032)
      else $error("internal por release time");
   a_strap_frozen:
      assert property (por_internal_n && $past(por_internal_n) |-> $stable(strap_cfg))
      else $error("straps changed outside por");
   a_wdt_starts_hard:
      assert property (watchdog_zero && watchdog_en && quiet |-> ##[1:6] hard_reset_pin_n_oe)
      else $error("watchdog reset missing");
   a_bm_starts_hard:
      assert property (bus_mon_zero && bus_mon_en && quiet |-> ##[1:6] hard_reset_pin_n_oe)
      else $error("bus monitor reset missing");
   a_tap_starts_soft:
      assert property (tap_soft_req && quiet |-> ##[1:6] soft_reset_pin_n_oe)
      else $error("tap soft reset missing");
   a_hard_release_time:
      assert property ($fell(hard_reset_pin_n_oe) |-> h_cnt_r >= 511 && h_cnt_r <= 516)
      else $error("hard release time");
   a_soft_release_time:
      assert property ($fell(soft_reset_pin_n_oe) |-> s_cnt_r >= 514 && s_cnt_r <= 520)
      else $error("soft release time");
   // sample pulse leads the pin enable by one cycle; por start samples at release instead
   a_hard_samples_cfg:
      assert property ($rose(hard_reset_pin_n_oe) && por_internal_n |-> $past(cfg_sample))
      else $error("no sample on hard reset");
   a_soft_keeps_cfg:
      // a hard pre-empt loads the word one cycle before its pin enable rises
      assert property (soft_reset_pin_n_oe && !hard_reset_pin_n_oe |=> (hard_reset_pin_n_oe
         || ($stable(hard_cfg) && !cfg_sample)) or ##1 hard_reset_pin_n_oe)
         else $error("soft reset changed config");
endmodule
bind mrc_top mrc_top_monitor u_mon (.*);

// File: verif/mrc_board.sv
`timescale 1ns/100ps
module mrc_board #(
   parameter int LOCK_DLY = 20
) (
   input wire logic clk,
   input wire logic pll_reset,
   input wire logic hard_oe,
   input wire logic soft_oe,
   input wire logic pull_hard,
   input wire logic pull_soft,
   output logic hard_n,
   output logic soft_n,
   output logic lock
);
   int cnt = 0;
   // wired-and with pull-ups: nobody ever drives high
   assign hard_n = !(hard_oe || pull_hard);
   assign soft_n = !(soft_oe || pull_soft);
   // lock comes late on purpose, never while pll held
   always @(posedge clk) begin
      if (pll_reset) cnt <= 0;
      else if (cnt < LOCK_DLY) cnt <= cnt + 1;
   end
   assign lock = (cnt == LOCK_DLY);
endmodule

// File: verif/multi_source_reset_controller_test.sv
`timescale 1ns/100ps
module multi_source_reset_controller_test;
   import mrc_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic power_on_reset_n = 1'b0;
   logic watchdog_zero = 1'b0, watchdog_en = 1'b1, bus_mon_zero = 1'b0, bus_mon_en = 1'b1;
   logic tap_soft_req = 1'b0, p_hard = 1'b0, p_soft = 1'b0;
   logic hard_reset_pin_n_i, hard_reset_pin_n_o, hard_reset_pin_n_oe, soft_reset_pin_n_i;
   logic soft_reset_pin_n_o, soft_reset_pin_n_oe, system_pll_lock, system_pll_reset;
   logic por_internal_n, core_reset_n, cfg_sample;
   mrc_strap_s strap_pins = '0, strap_cfg;
   logic [HARD_CFG_W-1:0] hard_cfg_word = '0, hard_cfg;
   mrc_status_s reset_status;
   int fail_count = 0, checks = 0, seed = 32'hc8ad_0e6c, i;
   logic [4:0] src;
   mrc_top u_dut (.*);
   mrc_board #(.LOCK_DLY(37)) u_board (.clk, .pll_reset(system_pll_reset),
      .hard_oe(hard_reset_pin_n_oe), .soft_oe(soft_reset_pin_n_oe), .pull_hard(p_hard),
      .pull_soft(p_soft), .hard_n(hard_reset_pin_n_i), .soft_n(soft_reset_pin_n_i),
      .lock(system_pll_lock));
   always #(CLK_PERIOD_NS / 2) clk = !clk;
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_core(input logic v, input int lim);
      for (int k = 0; k < lim && core_reset_n !== v; k++) cyc(1);
      chk(core_reset_n === v, "core reset timing");
   endtask
   // src order: watchdog, bus monitor, hard pin, soft pin, tap
   function automatic logic is_hard(input logic [4:0] s);
      return s[4] | s[3] | s[2];
   endfunction
   function automatic mrc_status_s exp_stat(input logic [4:0] s);
      if (is_hard(s)) return {1'b0, s[2], 1'b0, s[4], s[3], 1'b0};
      return {2'b00, s[1], 2'b00, s[0]};
   endfunction
   task automatic run(input logic [4:0] s, input logic mid);
      logic [31:0] w, oldc;
      mrc_strap_s st;
      w = $random(seed);
      oldc = hard_cfg;
      st = strap_cfg;
      hard_cfg_word = w;
      strap_pins = mrc_strap_s'($random(seed));
      // pins lead by the synchroniser lag so every source meets the same start edge
      {p_hard, p_soft} = s[2:1];
      cyc(2);
      {watchdog_zero, bus_mon_zero, tap_soft_req} = {s[4], s[3], s[0]};
      wait_core(1'b0, 20);
      cyc(5);
      {watchdog_zero, bus_mon_zero, p_hard, p_soft, tap_soft_req} = 5'h00;
      if (mid) begin
         cyc(100);
         p_soft = 1'b1;
         cyc(5);
         p_soft = 1'b0;
      end
      wait_core(1'b1, 800);
      chk(reset_status === exp_stat(s), "status");
      chk(hard_cfg === (is_hard(s) ? w : oldc), "hard config word");
      chk(strap_cfg === st, "straps changed");
      cyc(30);
      chk(core_reset_n === 1'b1, "spurious reset");
   endtask
   task automatic do_por();
      mrc_strap_s st;
      st = mrc_strap_s'($random(seed));
      strap_pins = st;
      power_on_reset_n = 1'b0;
      cyc(20);
      power_on_reset_n = 1'b1;
      cyc(6);
      strap_pins = ~st;
      wait_core(1'b1, 2000);
      chk(strap_cfg === st, "straps not captured");
      chk(reset_status === STATUS_INIT, "por status");
      chk(hard_reset_pin_n_i === 1'b1 && soft_reset_pin_n_i === 1'b1, "pins held");
   endtask
   // ------------------------------------------------
   // sequence
   // ------------------------------------------------
   initial begin
      #(30000 * CLK_PERIOD_NS);
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      report_and_stop();
   end
   initial begin
      cyc(16);
      resetn = 1'b1;
      do_por();
      for (i = 0; i < 5; i++) run(5'h10 >> i, i[0]);
      run(5'h11, 1'b0);
      {watchdog_en, bus_mon_en, watchdog_zero, bus_mon_zero} = 4'h3;
      cyc(30);
      chk(core_reset_n === 1'b1, "disabled source fired");
      {watchdog_en, bus_mon_en, watchdog_zero, bus_mon_zero} = 4'hc;
      for (i = 0; i < 6; i++) begin
         src = 5'($random(seed));
         run((src == 5'h00) ? 5'h01 : src, 1'b1);
      end
      tap_soft_req = 1'b1;
      wait_core(1'b0, 20);
      tap_soft_req = 1'b0;
      cyc(50);
      power_on_reset_n = 1'b0;
      cyc(5);
      chk(por_internal_n === 1'b0, "por not taking over");
      do_por();
      report_and_stop();
   end
endmodule
